// File: rtl/tsst_pkg.sv
/*
 Package for the touch scan timing sequencer: register offsets, field layout,
 reset values, delay tables, state encoding and carrier structs.
 Assumes a 40 MHz ref_clk; the 4 MHz state-machine tick is derived from it.
*/
package tsst_pkg;
  localparam int REF_CLK_HZ = 40000000;
  localparam int OSC_HZ = 4000000;
  localparam int OSC_DIV = (REF_CLK_HZ + OSC_HZ - 1) / OSC_HZ;
  localparam int CONV_CYCLES_10 = 10;
  localparam int CONV_CYCLES_12 = 12;

  localparam logic [3:0] ADDR_CFG0 = 4'h0;
  localparam logic [3:0] ADDR_CFG1 = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;

  localparam int CFG0_CLK_LO = 0;
  localparam int CFG0_CLK_HI = 1;
  localparam int CFG0_SETTLE_LSB = 2;
  localparam int CFG0_PRE_LSB = 5;
  localparam int CFG0_SENSE_LSB = 8;
  localparam int CFG0_RES12 = 11;
  localparam int CFG1_MODE_LSB = 0;
  localparam int CFG1_SAMP_LSB = 2;
  localparam int CFG1_BATCH_LSB = 4;
  localparam int CFG1_ENABLE = 7;
  localparam logic [11:0] CFG0_RESET = 12'h000;
  localparam logic [7:0] CFG1_RESET = 8'h00;

  // Delays in microseconds; converted to 4 MHz ticks (x4)
  localparam logic [15:0] SETTLE_US [8] = '{16'h0000, 16'h000a, 16'h0032, 16'h0064,
                                            16'h00c8, 16'h012c, 16'h01f4, 16'h03e8};
  localparam logic [15:0] PRE_US [8] = '{16'h0001, 16'h0002, 16'h0004, 16'h000a,
                                         16'h0014, 16'h0032, 16'h0064, 16'h00c8};
  localparam logic [15:0] SENSE_US [8] = '{16'h0001, 16'h0002, 16'h0004, 16'h000a,
                                           16'h0020, 16'h0040, 16'h0080, 16'h0100};
  localparam logic [15:0] BATCH_US [8] = '{16'h0000, 16'h0064, 16'h01f4, 16'h03e8,
                                           16'h07d0, 16'h0fa0, 16'h1388, 16'h2710};
  localparam int TICKS_PER_US = OSC_HZ / 1000000;

  typedef enum logic [1:0] {
    TSST_MODE_XY = 2'h0,
    TSST_MODE_XYZ = 2'h1,
    TSST_MODE_X = 2'h2,
    TSST_MODE_Y = 2'h3
  } tsst_mode_t;

  typedef enum logic [1:0] {
    TSST_AX_Y = 2'h0,
    TSST_AX_X = 2'h1,
    TSST_AX_Z = 2'h2
  } tsst_axis_t;

  typedef enum logic [6:0] {
    TSST_IDLE = 7'h01,
    TSST_SETTLE = 7'h02,
    TSST_CONV = 7'h04,
    TSST_PRE = 7'h08,
    TSST_SENSE = 7'h10,
    TSST_BATCH = 7'h20,
    TSST_ERR = 7'h40
  } tsst_state_t;

  typedef struct packed {
    logic xp_supply;
    logic xn_ground;
    logic yp_supply;
    logic yn_ground;
  } tsst_drive_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } tsst_bus_t;
endpackage : tsst_pkg

// File: rtl/tsst_clk_div.sv
/*
 Tick divider: emits one-cycle enables for the 4 MHz state clock and for the
 converter clock at that rate divided by 1, 2 or 4.
 Assumes a single ref_clk and async active-low reset.
*/
`timescale 1ns/1ps
module tsst_clk_div #(
  parameter int OSC_DIV = tsst_pkg::OSC_DIV
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [1:0] clk_divide_sel,
  output logic osc_tick,
  output logic conv_tick
);
  logic [7:0] pre_q, pre_d;
  logic [1:0] sub_q, sub_d;
  logic osc_q, osc_d, conv_q, conv_d;

  always_comb begin
    pre_d = pre_q + 8'h01;
    osc_d = 1'b0;
    conv_d = 1'b0;
    sub_d = sub_q;
    if (pre_q == 8'(OSC_DIV - 1)) begin
      pre_d = 8'h00;
      osc_d = 1'b1;
      sub_d = sub_q + 2'h1;
      case (clk_divide_sel)
        2'h0: conv_d = 1'b1;
        2'h1: conv_d = sub_q[0];
        default: conv_d = (sub_q == 2'h3);
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pre_q <= 8'h00;
      sub_q <= 2'h0;
      osc_q <= 1'b0;
      conv_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      sub_q <= sub_d;
      osc_q <= osc_d;
      conv_q <= conv_d;
    end
  end

  assign osc_tick = osc_q;
  assign conv_tick = conv_q;
endmodule : tsst_clk_div

// File: rtl/tsst_sequencer.sv
/*
 Touch scan timing sequencer: register port, drive-line control and the
 settle / convert / precharge / sense / batch sequence for one sample set.
 Assumes the converter core samples while conv_busy is high and that
 pen_down is synchronous to ref_clk.
*/
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module tsst_sequencer #(
  parameter int SAMPLE_MAX = 8
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic pen_down,
  output tsst_pkg::tsst_drive_t panel_drive,
  output logic conv_busy,
  output logic sample_strobe,
  output logic [1:0] sample_axis,
  output logic set_done
);
  logic osc_tick, conv_tick;
  logic [11:0] cfg0_q, cfg0_d;
  logic [7:0] cfg1_q, cfg1_d;
  logic [15:0] rdata_q, rdata_d;
  tsst_pkg::tsst_state_t st_q, st_d;
  tsst_pkg::tsst_axis_t ax_q, ax_d;
  tsst_pkg::tsst_drive_t drv_q, drv_d;
  logic [17:0] wait_q, wait_d;
  logic [3:0] bit_q, bit_d;
  logic [3:0] samp_q, samp_d;
  logic strobe_q, strobe_d, done_q, done_d, bad_q, bad_d;
  logic [1:0] clk_sel;
  logic res12;
  logic [3:0] conv_bits;
  logic [3:0] samp_target;
  logic [2:0] samp_count;
  tsst_pkg::tsst_mode_t mode;

  assign clk_sel = {cfg0_q[tsst_pkg::CFG0_CLK_HI], cfg0_q[tsst_pkg::CFG0_CLK_LO]};
  assign res12 = cfg0_q[tsst_pkg::CFG0_RES12];
  assign mode = tsst_pkg::tsst_mode_t'(cfg1_q[tsst_pkg::CFG1_MODE_LSB +: 2]);
  assign conv_bits = res12 ? 4'(tsst_pkg::CONV_CYCLES_12) : 4'(tsst_pkg::CONV_CYCLES_10);
  // Three bits so a field of 3 gives four samples, not zero
  assign samp_count = {1'b0, cfg1_q[tsst_pkg::CFG1_SAMP_LSB +: 2]} + 3'h1;
  // Pressure takes two groups, so twice the per-coordinate count
  assign samp_target = (ax_q == tsst_pkg::TSST_AX_Z) ? {samp_count, 1'b0} : {1'b0, samp_count};

  tsst_clk_div u_div (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clk_divide_sel(clk_sel),
    .osc_tick(osc_tick),
    .conv_tick(conv_tick)
  );

  function automatic logic [17:0] us_ticks(input logic [15:0] us);
    us_ticks = 18'(us) * 18'(tsst_pkg::TICKS_PER_US);
  endfunction : us_ticks

  function automatic tsst_pkg::tsst_drive_t axis_drive(input tsst_pkg::tsst_axis_t ax);
    axis_drive = '0;
    case (ax)
      tsst_pkg::TSST_AX_Y: axis_drive = '{xp_supply: 1'b0, xn_ground: 1'b0, yp_supply: 1'b1, yn_ground: 1'b1};
      tsst_pkg::TSST_AX_X: axis_drive = '{xp_supply: 1'b1, xn_ground: 1'b1, yp_supply: 1'b0, yn_ground: 1'b0};
      tsst_pkg::TSST_AX_Z: axis_drive = '{xp_supply: 1'b0, xn_ground: 1'b1, yp_supply: 1'b1, yn_ground: 1'b0};
      default: axis_drive = '0;
    endcase
  endfunction : axis_drive

  function automatic tsst_pkg::tsst_axis_t first_axis(input tsst_pkg::tsst_mode_t m);
    first_axis = (m == tsst_pkg::TSST_MODE_X) ? tsst_pkg::TSST_AX_X : tsst_pkg::TSST_AX_Y;
  endfunction : first_axis

  // Register port
  always_comb begin
    cfg0_d = cfg0_q;
    cfg1_d = cfg1_q;
    rdata_d = 16'h0000;
    if (reg_wr && reg_addr == tsst_pkg::ADDR_CFG0) begin
      cfg0_d = reg_wdata[11:0];
    end
    if (reg_wr && reg_addr == tsst_pkg::ADDR_CFG1) begin
      cfg1_d = reg_wdata[7:0];
    end
    if (reg_rd) begin
      case (reg_addr)
        tsst_pkg::ADDR_CFG0: rdata_d = {4'h0, cfg0_q};
        tsst_pkg::ADDR_CFG1: rdata_d = {8'h00, cfg1_q};
        tsst_pkg::ADDR_STATUS: rdata_d = {bad_q, 6'h00, st_q, ax_q};
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfg0_q <= tsst_pkg::CFG0_RESET;
      cfg1_q <= tsst_pkg::CFG1_RESET;
      rdata_q <= 16'h0000;
    end else begin
      cfg0_q <= cfg0_d;
      cfg1_q <= cfg1_d;
      rdata_q <= rdata_d;
    end
  end

  // Scan sequence
  always_comb begin
    st_d = st_q;
    ax_d = ax_q;
    drv_d = drv_q;
    wait_d = wait_q;
    bit_d = bit_q;
    samp_d = samp_q;
    strobe_d = 1'b0;
    done_d = 1'b0;
    bad_d = bad_q;
    case (st_q)
      tsst_pkg::TSST_IDLE: begin
        drv_d = '0;
        if (cfg1_q[tsst_pkg::CFG1_ENABLE] && pen_down) begin
          // 12-bit at undivided clock is refused rather than converted badly
          if (res12 && clk_sel == 2'h0) begin
            bad_d = 1'b1;
            st_d = tsst_pkg::TSST_ERR;
          end else begin
            bad_d = 1'b0;
            ax_d = first_axis(mode);
            drv_d = axis_drive(first_axis(mode));
            wait_d = us_ticks(tsst_pkg::SETTLE_US[cfg0_q[tsst_pkg::CFG0_SETTLE_LSB +: 3]]);
            samp_d = 4'h0;
            st_d = tsst_pkg::TSST_SETTLE;
          end
        end
      end
      tsst_pkg::TSST_SETTLE: begin
        // Driver held on; settle time costs drive current
        if (wait_q == 18'h0) begin
          bit_d = 4'h0;
          st_d = tsst_pkg::TSST_CONV;
        end else if (osc_tick) begin
          wait_d = wait_q - 18'h1;
        end
      end
      tsst_pkg::TSST_CONV: begin
        if (conv_tick) begin
          if (bit_q == conv_bits - 4'h1) begin
            bit_d = 4'h0;
            strobe_d = 1'b1;
            samp_d = samp_q + 4'h1;
            if (samp_q + 4'h1 == samp_target) begin
              drv_d = '0;
              samp_d = 4'h0;
              if ((mode == tsst_pkg::TSST_MODE_XY && ax_q == tsst_pkg::TSST_AX_Y) ||
                  (mode == tsst_pkg::TSST_MODE_XYZ && ax_q != tsst_pkg::TSST_AX_Z)) begin
                wait_d = us_ticks(tsst_pkg::PRE_US[cfg0_q[tsst_pkg::CFG0_PRE_LSB +: 3]]);
                st_d = tsst_pkg::TSST_PRE;
              end else begin
                done_d = 1'b1;
                wait_d = us_ticks(tsst_pkg::BATCH_US[cfg1_q[tsst_pkg::CFG1_BATCH_LSB +: 3]]);
                st_d = tsst_pkg::TSST_BATCH;
              end
            end
          end else begin
            bit_d = bit_q + 4'h1;
          end
        end
      end
      tsst_pkg::TSST_PRE: begin
        drv_d = '0;
        if (wait_q == 18'h0) begin
          wait_d = us_ticks(tsst_pkg::SENSE_US[cfg0_q[tsst_pkg::CFG0_SENSE_LSB +: 3]]);
          st_d = tsst_pkg::TSST_SENSE;
        end else if (osc_tick) begin
          wait_d = wait_q - 18'h1;
        end
      end
      tsst_pkg::TSST_SENSE: begin
        drv_d = '0;
        if (wait_q == 18'h0) begin
          ax_d = (ax_q == tsst_pkg::TSST_AX_Y) ? tsst_pkg::TSST_AX_X : tsst_pkg::TSST_AX_Z;
          drv_d = axis_drive((ax_q == tsst_pkg::TSST_AX_Y) ? tsst_pkg::TSST_AX_X : tsst_pkg::TSST_AX_Z);
          wait_d = us_ticks(tsst_pkg::SETTLE_US[cfg0_q[tsst_pkg::CFG0_SETTLE_LSB +: 3]]);
          st_d = tsst_pkg::TSST_SETTLE;
        end else if (osc_tick) begin
          wait_d = wait_q - 18'h1;
        end
      end
      tsst_pkg::TSST_BATCH: begin
        drv_d = '0;
        if (wait_q == 18'h0) begin
          st_d = tsst_pkg::TSST_IDLE;
        end else if (osc_tick) begin
          wait_d = wait_q - 18'h1;
        end
      end
      tsst_pkg::TSST_ERR: begin
        drv_d = '0;
        if (!(res12 && clk_sel == 2'h0) || !cfg1_q[tsst_pkg::CFG1_ENABLE]) begin
          st_d = tsst_pkg::TSST_IDLE;
        end
      end
      default: begin
        drv_d = '0;
        st_d = tsst_pkg::TSST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= tsst_pkg::TSST_IDLE;
      ax_q <= tsst_pkg::TSST_AX_Y;
      drv_q <= '0;
      wait_q <= 18'h0;
      bit_q <= 4'h0;
      samp_q <= 4'h0;
      strobe_q <= 1'b0;
      done_q <= 1'b0;
      bad_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ax_q <= ax_d;
      drv_q <= drv_d;
      wait_q <= wait_d;
      bit_q <= bit_d;
      samp_q <= samp_d;
      strobe_q <= strobe_d;
      done_q <= done_d;
      bad_q <= bad_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign panel_drive = drv_q;
  assign conv_busy = (st_q == tsst_pkg::TSST_CONV);
  assign sample_strobe = strobe_q;
  assign sample_axis = ax_q;
  assign set_done = done_q;
endmodule : tsst_sequencer

// File: sim/tsst_seq_sva.sv
/*
 Checker for the tsst_sequencer ports: drive patterns, pulses, read data.
 Assumes it is bound to tsst_sequencer from the testbench top file.
*/
`timescale 1ns/1ps
module tsst_seq_sva (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire tsst_pkg::tsst_drive_t panel_drive,
  input wire logic conv_busy,
  input wire logic sample_strobe,
  input wire logic [1:0] sample_axis,
  input wire logic set_done
);
  logic [3:0] drv;
  assign drv = panel_drive;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_drive_legal: assert property (drv inside {4'h0, 4'h3, 4'hc, 4'h6})
    else $error("drive pattern not allowed");
  a_conv_axis: assert property (conv_busy |-> drv == (sample_axis == 2'h0 ? 4'h3 :
    (sample_axis == 2'h1 ? 4'hc : 4'h6))) else $error("drive off or wrong axis in conversion");
  a_no_hop: assert property ($past(drv) != 4'h0 && drv != 4'h0 |-> drv == $past(drv))
    else $error("drive moved to another axis without a gap");
  a_off_after_set: assert property (set_done |-> (drv == 4'h0) [*2])
    else $error("drive on right after set end");
  a_strobe_gap: assert property (sample_strobe |=> !sample_strobe [*8])
    else $error("conversions too short");
  a_done_pulse: assert property (set_done |=> !set_done [*8])
    else $error("set end not a single pulse");
  a_y_first: assert property ($changed(sample_axis) && sample_axis == 2'h1 |-> $past(sample_axis) == 2'h0)
    else $error("x not preceded by y");
  a_rdata_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read slot");
  c_set: cover property (set_done);
  c_press: cover property (sample_strobe && sample_axis == 2'h2);
  c_x_conv: cover property (conv_busy && drv == 4'hc);
endmodule : tsst_seq_sva

// File: sim/tsst_panel_model.sv
/*
 Panel model: turns the bench's touch level into pen_down.
 Assumes ref_clk from the bench; touch is sensed only while drivers are off.
*/
`timescale 1ns/1ps
module tsst_panel_model (
  input wire logic ref_clk,
  input wire logic touch,
  input wire tsst_pkg::tsst_drive_t panel_drive,
  output logic pen_down
);
  // Registered so pen_down stays synchronous to ref_clk
  // Pen detection needs the panel undriven, so it holds while driven
  always_ff @(posedge ref_clk) begin
    if (panel_drive == '0) begin
      pen_down <= touch;
    end
  end
endmodule : tsst_panel_model

// File: sim/testbench.sv
/*
 Self-checking bench for tsst_sequencer with the panel model and checker.
 Assumes tsst_pkg, the design, the model and the checker are compiled first.
*/
`timescale 1ns/1ps
module testbench;
  logic ref_clk, rstn, reg_wr, reg_rd, touch, pen_down, conv_busy, sample_strobe, set_done;
  logic [3:0] reg_addr, drv, prev;
  logic [15:0] reg_wdata, reg_rdata;
  logic [1:0] sample_axis;
  logic [11:0] seq;
  logic timed_out;
  tsst_pkg::tsst_drive_t panel_drive;
  int mismatches, samples_checked, cyc, t_on, t_off, t_st, t_dn, settle, gap, bgap, per, ndone, nstrobe, ndrv;
  assign drv = panel_drive;
  tsst_sequencer tsst_sequencer_inst (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .pen_down, .panel_drive, .conv_busy, .sample_strobe, .sample_axis, .set_done);
  tsst_panel_model tsst_panel_model_inst (.ref_clk, .touch, .panel_drive, .pen_down);
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Sampled on the falling edge so outputs have settled
  always @(negedge ref_clk) begin
    cyc++;
    if (prev == 4'h0 && drv != 4'h0) begin
      seq = {seq[7:0], drv};
      gap = cyc - t_off;
      if (t_dn > t_on) bgap = cyc - t_dn;
      t_on = cyc;
      settle = -1;
      ndrv++;
    end
    if (prev != 4'h0 && drv == 4'h0) t_off = cyc;
    if (conv_busy && settle == -1) settle = cyc - t_on;
    if (sample_strobe) begin
      per = cyc - t_st;
      t_st = cyc;
      nstrobe++;
    end
    if (set_done) begin
      t_dn = cyc;
      ndone++;
    end
    prev = drv;
  end
  function automatic logic near(input int a, input int e);
    // Tick phase of the divided clocks blurs timings by about one tick
    return (a - e <= 12) && (e - a <= 12);
  endfunction : near
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] expv);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, expv);
    @(posedge ref_clk);
  endtask : rd
  task automatic wait_done(input int n);
    for (int i = 0; i < 30000 && ndone < n && !timed_out; i++) @(posedge ref_clk);
    if (ndone < n) begin
      mismatches++;
      timed_out = 1'b1;
    end
  endtask : wait_done
  task automatic restart();
    touch <= 1'b0;
    rstn <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    ndone = 0;
    nstrobe = 0;
    ndrv = 0;
    seq = 12'h000;
    @(posedge ref_clk);
  endtask : restart
  task automatic run(input logic [15:0] c0, input logic [15:0] c1);
    wr(4'h0, c0);
    wr(4'h4, c1);
    touch <= 1'b1;
  endtask : run
  initial begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    touch = 1'b0;
    timed_out = 1'b0;
    restart();
    rd(4'h0, 16'h0000);
    rd(4'h4, 16'h0000);
    wr(4'h0, 16'hffff);
    wr(4'h4, 16'h007f);
    rd(4'h0, 16'h0fff);
    rd(4'h4, 16'h007f);
    rd(4'hc, 16'h0000);
    $display("test registers ended");
    // Y only (X only at f 3), two samples: strobe spacing shows the converter rate
    for (int f = 0; f < 4; f++) begin
      restart();
      run(16'(f), (f == 3) ? 16'h0086 : 16'h0087);
      wait_done(1);
      check(near(per, f == 0 ? 100 : (f == 1 ? 200 : 400)), 1'b1);
      check(seq, (f == 3) ? 12'h00c : 12'h003);
      check(sample_axis, (f == 3) ? 2'h1 : 2'h0);
      if (f == 0) check(near(settle, 0), 1'b1);
    end
    $display("test divider ended");
    restart();
    run(16'h0800, 16'h008d);
    repeat (300) @(posedge ref_clk);
    check(ndrv, 0);
    rd(4'h8, {1'b1, 6'h00, tsst_pkg::TSST_ERR, 2'h0});
    wr(4'h0, 16'h0801);
    wait_done(1);
    check(seq, 12'h3c6);
    check(nstrobe, 16);
    check(near(per, tsst_pkg::CONV_CYCLES_12 * 20), 1'b1);
    $display("test bad config ended");
    // Settle 10 us, precharge 10 us, sense 1 us, batch 100 us
    restart();
    run(16'h0065, 16'h0091);
    wait_done(1);
    check(seq, 12'h3c6);
    check(nstrobe, 4);
    check(near(settle, 400), 1'b1);
    check(near(gap, 440), 1'b1);
    wr(4'h4, 16'h0090);
    wait_done(2);
    check(near(bgap, 4000), 1'b1);
    check(seq, 12'h63c);
    $display("test sequence ended");
    print_verdict();
  end
endmodule : testbench
bind tsst_sequencer tsst_seq_sva tsst_seq_sva_inst (.ref_clk, .rstn, .reg_rd, .reg_rdata, .panel_drive,
  .conv_busy, .sample_strobe, .sample_axis, .set_done);
